/* File: logic/palette_pkg.sv */
// Constants for the layer palette block: map, entry fields, timing.
// Assumes a 32-bit AHB-Lite window at the display register base.
// Contract
// - Indirect mode: pixel code indexes layer table
// - Blue component held in bits 7:2
// - Green component held in bits 15:10
// - Red component held in bits 23:18
// - Bit 31 set lets entry's pixels blend
// - Unused bits zero; colours undefined after reset
// - Layer one table spans 0x800 to 0xBFF
// - Layer two table spans 0x1000 to 0x13FF
// - Layer three table spans 0x1400 to 0x17FF
`default_nettype none

package palette_pkg;
    localparam int NUM_LAYERS = 3;
    localparam int ADDR_W = 13;
    localparam int IDX_W = 8;
    localparam int IDX_LSB = 2;
    localparam int DEPTH = 256;
    localparam int CW = 6;
    localparam int RGB_W = 18;
    localparam int ENTRY_W = 19;

    localparam logic [ADDR_W-1:0] TBL_SPAN = 13'h03FF;
    localparam logic [NUM_LAYERS-1:0][ADDR_W-1:0] TBL_BASE =
        {13'h1400, 13'h1000, 13'h0800};
    localparam logic [ADDR_W-1:0] CTRL_OFS = 13'h1C00;
    localparam logic [ADDR_W-1:0] STAT_OFS = 13'h1C04;

    // Bus word layout
    localparam int B_LSB = 2;
    localparam int G_LSB = 10;
    localparam int R_LSB = 18;
    localparam int A_BIT = 31;
    localparam logic [31:0] ENTRY_MASK = 32'h80FC_FCFC;

    // Stored entry layout
    localparam int EB_LSB = 0;
    localparam int EG_LSB = 6;
    localparam int ER_LSB = 12;
    localparam int EA_BIT = 18;

    // Control and status words
    localparam int CTRL_BLEND_BIT = 3;
    localparam int STAT_CNT_LSB = 16;
    localparam int CNT_W = 16;
    localparam logic [NUM_LAYERS-1:0] CTRL_IND_RST = 3'h0;
    localparam logic CTRL_BLEND_RST = 1'b0;

    // Pixel code to colour, and read wait states
    localparam int PIX_LAT = 2;
    localparam int READ_WAIT = 1;

    function automatic logic [ENTRY_W-1:0] entry_pack(
        input logic [31:0] w);
        return {w[A_BIT], w[R_LSB +: CW], w[G_LSB +: CW], w[B_LSB +: CW]};
    endfunction

    function automatic logic [31:0] entry_word(
        input logic [ENTRY_W-1:0] e);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[A_BIT] = e[EA_BIT];
        w[R_LSB +: CW] = e[ER_LSB +: CW];
        w[G_LSB +: CW] = e[EG_LSB +: CW];
        w[B_LSB +: CW] = e[EB_LSB +: CW];
        return w;
    endfunction
endpackage

`default_nettype wire

/* File: logic/palette_table.sv */
// One layer colour table: one write port, a bus read port and a
// registered pixel read port. Assumes writes come from one bus slave.
`default_nettype none

module palette_table #(
    parameter int DEPTH = 256,
    parameter int IDX_W = 8,
    parameter int ENTRY_W = 19
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus side
    input wire logic we,
    input wire logic [IDX_W-1:0] widx,
    input wire logic [ENTRY_W-1:0] wentry,
    input wire logic [IDX_W-1:0] bus_idx,
    output logic [ENTRY_W-1:0] bus_entry,
    // Pixel side
    input wire logic pix_re,
    input wire logic [IDX_W-1:0] pix_idx,
    output logic [ENTRY_W-1:0] pix_entry
);
    // Only the stored fields exist, so unused bits cannot hold data
    logic [ENTRY_W-1:0] mem [DEPTH];

    // No reset: colours stay undefined until software fills them
    always_ff @(posedge hclk) begin
        if (we) begin
            mem[widx] <= wentry;
        end
    end

    assign bus_entry = mem[bus_idx];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pix_entry <= '0;
        end else if (pix_re) begin
            pix_entry <= mem[pix_idx];
        end
    end
endmodule

`default_nettype wire

/* File: logic/pixel_stage.sv */
// Output stage of one layer: picks palette or direct colour and the
// blend flag. Assumes the entry arrives one cycle after the code.
`default_nettype none

module pixel_stage (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // From the lookup
    input wire logic valid,
    input wire logic indirect,
    input wire logic blend_en,
    input wire logic [palette_pkg::ENTRY_W-1:0] entry,
    input wire logic [palette_pkg::RGB_W-1:0] direct,
    // Colour out
    output logic out_valid,
    output logic [palette_pkg::CW-1:0] out_red,
    output logic [palette_pkg::CW-1:0] out_green,
    output logic [palette_pkg::CW-1:0] out_blue,
    output logic out_blend
);
    import palette_pkg::*;

    logic [CW-1:0] red_d;
    logic [CW-1:0] green_d;
    logic [CW-1:0] blue_d;
    logic blend_d;

    assign red_d = indirect ? entry[ER_LSB +: CW] : direct[2*CW +: CW];
    assign green_d = indirect ? entry[EG_LSB +: CW] : direct[CW +: CW];
    assign blue_d = indirect ? entry[EB_LSB +: CW] : direct[0 +: CW];
    // In indirect mode, entry flag clear stops blending even with blend mode on
    assign blend_d = blend_en & (~indirect | entry[EA_BIT]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_valid <= 1'b0;
            out_red <= '0;
            out_green <= '0;
            out_blue <= '0;
            out_blend <= 1'b0;
        end else begin
            out_valid <= valid;
            out_red <= red_d;
            out_green <= green_d;
            out_blue <= blue_d;
            out_blend <= blend_d;
        end
    end
endmodule

`default_nettype wire

/* File: logic/layer_color_palette_lookup.sv */
// Layer palette block: AHB-Lite window over three colour tables,
// a control word and a status word, and per-layer pixel lookup.
// Assumes hclk is the display clock and this slave drives hready.
`default_nettype none

module layer_color_palette_lookup (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,

    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,

    // Pixel codes in
    input wire logic [palette_pkg::NUM_LAYERS-1:0] pix_valid,
    input wire logic [palette_pkg::NUM_LAYERS-1:0]
        [palette_pkg::IDX_W-1:0] pix_code,
    input wire logic [palette_pkg::NUM_LAYERS-1:0]
        [palette_pkg::RGB_W-1:0] pix_direct,

    // Colours out
    output logic [palette_pkg::NUM_LAYERS-1:0] out_valid,
    output logic [palette_pkg::NUM_LAYERS-1:0]
        [palette_pkg::CW-1:0] out_red,
    output logic [palette_pkg::NUM_LAYERS-1:0]
        [palette_pkg::CW-1:0] out_green,
    output logic [palette_pkg::NUM_LAYERS-1:0]
        [palette_pkg::CW-1:0] out_blue,
    output logic [palette_pkg::NUM_LAYERS-1:0] out_blend
);
    import palette_pkg::*;

    // Address phase
    logic [ADDR_W-1:0] a_addr;
    logic accept;

    assign a_addr = haddr[ADDR_W-1:0];
    assign accept = hsel & htrans[1] & hready;

    // Data phase state
    logic dp_act_q;
    logic dp_write_q;
    logic rd_wait_q;
    logic [ADDR_W-1:0] dp_addr_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_act_q <= 1'b0;
            dp_write_q <= 1'b0;
            rd_wait_q <= 1'b0;
            dp_addr_q <= '0;
        end else begin
            dp_act_q <= accept | (dp_act_q & ~hreadyout);
            rd_wait_q <= accept & ~hwrite;
            if (accept) begin
                dp_write_q <= hwrite;
                dp_addr_q <= a_addr;
            end
        end
    end

    // Reads wait one cycle so a write just ahead has landed first
    assign hreadyout = ~rd_wait_q;
    assign hresp = 1'b0;

    // Data phase decode
    logic [NUM_LAYERS-1:0] dp_tbl;
    logic dp_ctrl;
    logic dp_stat;
    logic [IDX_W-1:0] dp_idx;
    logic wr_fire;
    logic rd_load;
    logic tbl_wr;

    genvar g;
    generate
        for (g = 0; g < NUM_LAYERS; g++) begin : g_dec
            assign dp_tbl[g] =
                (dp_addr_q & ~TBL_SPAN) == TBL_BASE[g];
        end
    endgenerate

    assign dp_ctrl = dp_addr_q == CTRL_OFS;
    assign dp_stat = dp_addr_q == STAT_OFS;
    assign dp_idx = dp_addr_q[IDX_LSB +: IDX_W];
    assign wr_fire = dp_act_q & dp_write_q;
    assign rd_load = dp_act_q & rd_wait_q;
    assign tbl_wr = wr_fire & (|dp_tbl);

    // Control word: indirect mode per layer, global blend mode
    logic [NUM_LAYERS-1:0] ctrl_ind_q;
    logic ctrl_blend_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ind_q <= CTRL_IND_RST;
            ctrl_blend_q <= CTRL_BLEND_RST;
        end else if (wr_fire & dp_ctrl) begin
            ctrl_ind_q <= hwdata[NUM_LAYERS-1:0];
            ctrl_blend_q <= hwdata[CTRL_BLEND_BIT];
        end
    end

    // Palette write counter, wraps silently
    logic [CNT_W-1:0] wr_cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_cnt_q <= '0;
        end else if (tbl_wr) begin
            wr_cnt_q <= wr_cnt_q + 1'b1;
        end
    end

    // Lookup pipeline, first stage
    logic [NUM_LAYERS-1:0] v1_q;
    logic [NUM_LAYERS-1:0] ind1_q;
    logic [NUM_LAYERS-1:0] bl1_q;
    logic [NUM_LAYERS-1:0][RGB_W-1:0] dir1_q;
    logic [NUM_LAYERS-1:0][ENTRY_W-1:0] pix_entry;
    logic [NUM_LAYERS-1:0][ENTRY_W-1:0] bus_entry;

    generate
        for (g = 0; g < NUM_LAYERS; g++) begin : g_layer
            // Mode is caught with the code so a change mid-line
            // never splits one pixel between two modes
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    v1_q[g] <= 1'b0;
                    ind1_q[g] <= 1'b0;
                    bl1_q[g] <= 1'b0;
                    dir1_q[g] <= '0;
                end else begin
                    v1_q[g] <= pix_valid[g];
                    ind1_q[g] <= ctrl_ind_q[g];
                    bl1_q[g] <= ctrl_blend_q;
                    dir1_q[g] <= pix_direct[g];
                end
            end

            palette_table #(
                .DEPTH(DEPTH),
                .IDX_W(IDX_W),
                .ENTRY_W(ENTRY_W)
            ) u_table (
                .hclk(hclk),
                .hresetn(hresetn),
                .we(wr_fire & dp_tbl[g]),
                .widx(dp_idx),
                .wentry(entry_pack(hwdata)),
                .bus_idx(dp_idx),
                .bus_entry(bus_entry[g]),
                .pix_re(pix_valid[g]),
                .pix_idx(pix_code[g]),
                .pix_entry(pix_entry[g])
            );

            pixel_stage u_stage (
                .hclk(hclk),
                .hresetn(hresetn),
                .valid(v1_q[g]),
                .indirect(ind1_q[g]),
                .blend_en(bl1_q[g]),
                .entry(pix_entry[g]),
                .direct(dir1_q[g]),
                .out_valid(out_valid[g]),
                .out_red(out_red[g]),
                .out_green(out_green[g]),
                .out_blue(out_blue[g]),
                .out_blend(out_blend[g])
            );
        end
    endgenerate

    // Status word: write count and lookups in flight
    logic [31:0] stat_w;
    logic [NUM_LAYERS-1:0] busy_w;

    assign busy_w = v1_q & ind1_q;
    assign stat_w = {wr_cnt_q,
        {(STAT_CNT_LSB-NUM_LAYERS){1'b0}}, busy_w};

    // Read mux, unmapped addresses read zero
    logic [31:0] rd_mux;

    assign rd_mux = dp_ctrl ? {{(31-CTRL_BLEND_BIT){1'b0}},
                               ctrl_blend_q, ctrl_ind_q} :
                    dp_stat ? stat_w :
                    dp_tbl[0] ? entry_word(bus_entry[0]) :
                    dp_tbl[1] ? entry_word(bus_entry[1]) :
                    dp_tbl[2] ? entry_word(bus_entry[2]) :
                    32'h0000_0000;

    logic [31:0] hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_load) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hrdata = hrdata_q;

    // Checks
    default clocking cb @(posedge hclk);
    endclocking

    default disable iff (!hresetn);

    sequence tbl_rd_taken;
        accept && !hwrite && a_addr >= TBL_BASE[0]
        && a_addr <= (TBL_BASE[NUM_LAYERS-1] | TBL_SPAN);
    endsequence

    sequence rd_served;
        !hreadyout ##1 hreadyout;
    endsequence

    sequence wr_then_rd;
        (accept && hwrite && a_addr >= TBL_BASE[0]
        && a_addr <= (TBL_BASE[0] | TBL_SPAN))
        ##1 (accept && !hwrite && a_addr == $past(a_addr));
    endsequence

    rd_wait_a: assert property (
        tbl_rd_taken |=> rd_served)
        else $error("Palette read did not take one wait state");

    l1_decode_a: assert property (
        accept && a_addr >= TBL_BASE[0]
        && a_addr <= (TBL_BASE[0] | TBL_SPAN)
        |=> dp_tbl == 3'h1)
        else $error("Layer one range decoded wrongly");

    l2_decode_a: assert property (
        accept && a_addr >= TBL_BASE[1]
        && a_addr <= (TBL_BASE[1] | TBL_SPAN)
        |=> dp_tbl == 3'h2)
        else $error("Layer two range decoded wrongly");

    l3_decode_a: assert property (
        accept && a_addr >= TBL_BASE[2]
        && a_addr <= (TBL_BASE[2] | TBL_SPAN)
        |=> dp_tbl == 3'h4)
        else $error("Layer three range decoded wrongly");

    unused_zero_a: assert property (
        dp_act_q && !dp_write_q && hreadyout && |dp_tbl
        |-> (hrdata & ~ENTRY_MASK) == 32'h0000_0000)
        else $error("Unused palette bits read nonzero");

    read_back_a: assert property (
        wr_then_rd |-> ##2 hreadyout
        && hrdata == ($past(hwdata, 2) & ENTRY_MASK))
        else $error("Palette entry did not read back");

    unmapped_a: assert property (
        dp_act_q && !dp_write_q && hreadyout
        && !(|dp_tbl) && !dp_ctrl && !dp_stat
        |-> hrdata == 32'h0000_0000)
        else $error("Unmapped read returned data");

    rd_wait_once_a: assert property (
        !hreadyout |=> hreadyout)
        else $error("Read wait state lasted more than one cycle");

    wr_no_wait_a: assert property (
        accept && hwrite |=> hreadyout)
        else $error("Write data phase was stretched");

    ctrl_write_a: assert property (
        wr_fire && dp_ctrl
        |=> ctrl_ind_q == $past(hwdata[NUM_LAYERS-1:0])
        && ctrl_blend_q == $past(hwdata[CTRL_BLEND_BIT]))
        else $error("Control word write not taken");

    ctrl_read_a: assert property (
        rd_load && dp_ctrl
        |=> hrdata == {28'h000_0000, ctrl_blend_q, ctrl_ind_q})
        else $error("Control word read back wrongly");

    stat_read_a: assert property (
        rd_load && dp_stat
        |=> hrdata[31:STAT_CNT_LSB] == $past(wr_cnt_q))
        else $error("Write count read back wrongly");

    wr_count_a: assert property (
        tbl_wr |=> wr_cnt_q == $past(wr_cnt_q) + 16'h0001)
        else $error("Palette write not counted");

    gap_write_a: assert property (
        wr_fire && !(|dp_tbl) |=> wr_cnt_q == $past(wr_cnt_q))
        else $error("Write outside the tables was counted");

    generate
        for (g = 0; g < NUM_LAYERS; g++) begin : g_chk
            lookup_lat_a: assert property (
                pix_valid[g] |-> ##2 out_valid[g])
                else $error("Pixel colour late or missing");

            blue_a: assert property (
                out_valid[g] && $past(ind1_q[g])
                |-> out_blue[g] == $past(pix_entry[g][EB_LSB +: CW]))
                else $error("Blue not taken from entry");

            green_a: assert property (
                out_valid[g] && $past(ind1_q[g])
                |-> out_green[g] == $past(pix_entry[g][EG_LSB +: CW]))
                else $error("Green not taken from entry");

            red_a: assert property (
                out_valid[g] && $past(ind1_q[g])
                |-> out_red[g] == $past(pix_entry[g][ER_LSB +: CW]))
                else $error("Red not taken from entry");

            blend_a: assert property (
                out_valid[g] && $past(ind1_q[g])
                |-> out_blend[g] ==
                ($past(pix_entry[g][EA_BIT]) & $past(bl1_q[g])))
                else $error("Blend flag not honoured");

            direct_a: assert property (
                out_valid[g] && !$past(ind1_q[g])
                |-> {out_red[g], out_green[g], out_blue[g]}
                == $past(dir1_q[g]))
                else $error("Direct colour not passed through");

            direct_blend_a: assert property (
                out_valid[g] && !$past(ind1_q[g])
                |-> out_blend[g] == $past(bl1_q[g]))
                else $error("Blend mode not applied to direct colour");

            mode_capture_a: assert property (
                pix_valid[g] |=> ind1_q[g] == $past(ctrl_ind_q[g]))
                else $error("Layer mode not caught with the code");
        end
    endgenerate
endmodule

`default_nettype wire

/* File: dv/layer_color_palette_lookup_tb.sv */
// Self-checking bench for the layer palette block: AHB-Lite accesses
// to the three colour tables, control word and pixel lookups.
// Assumes the block is the only slave, so hready is its hreadyout.
`default_nettype none

module layer_color_palette_lookup_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import palette_pkg::*;

    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [NUM_LAYERS-1:0] pix_valid;
    logic [NUM_LAYERS-1:0][IDX_W-1:0] pix_code;
    logic [NUM_LAYERS-1:0][RGB_W-1:0] pix_direct;
    logic [NUM_LAYERS-1:0] out_valid;
    logic [NUM_LAYERS-1:0][CW-1:0] out_red;
    logic [NUM_LAYERS-1:0][CW-1:0] out_green;
    logic [NUM_LAYERS-1:0][CW-1:0] out_blue;
    logic [NUM_LAYERS-1:0] out_blend;
    int failures;
    int check_count;
    logic [31:0] rd;
    logic [31:0] base [3] = '{32'h0000_0800, 32'h0000_1000, 32'h0000_1400};
    // Index 0 of each row goes to entry 0, index 1 to entry 255
    logic [31:0] pat [3][2] = '{'{32'hFFFF_FFFF, 32'h7A5C_3CA9},
        '{32'h8123_4567, 32'h0F0F_F0F0}, '{32'hC0FC_0004, 32'h3B6D_92E1}};

    layer_color_palette_lookup i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .pix_valid(pix_valid), .pix_code(pix_code),
        .pix_direct(pix_direct), .out_valid(out_valid), .out_red(out_red),
        .out_green(out_green), .out_blue(out_blue), .out_blend(out_blend)
    );

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask

    // Ends on the edge where hready is sampled high
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, hreadyout, 1'b1);
            failures++;
            end_of_test();
        end
    endtask

    task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= 1'b1;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask

    task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= 1'b0;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        wait_ready();
        d = hrdata;
    endtask

    // Write then read of one address with no idle cycle between them
    task automatic bus_wr_rd(input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= 1'b1;
        wait_ready();
        hwrite <= 1'b0;
        hwdata <= d;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        wait_ready();
        q = hrdata;
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    // Same code on all three layers, colours checked two edges later
    task automatic pix_all(input int j, input logic bm);
        int i;
        logic [31:0] w;
        @(posedge hclk);
        pix_valid <= 3'h7;
        for (i = 0; i < 3; i++) begin
            pix_code[i] <= (j == 0) ? 8'h00 : 8'hFF;
        end
        @(posedge hclk);
        pix_valid <= 3'h0;
        @(posedge hclk);
        #1;
        chk({29'h0000_0000, out_valid}, 32'h0000_0007);
        for (i = 0; i < 3; i++) begin
            w = pat[i][j];
            chk({13'h0000, out_blend[i], out_red[i], out_green[i],
                out_blue[i]}, {13'h0000, bm & w[31], w[23:18], w[15:10],
                w[7:2]});
        end
    endtask

    initial begin
        int i;
        int j;
        failures = 0;
        check_count = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        pix_valid = 3'h0;
        pix_code = '0;
        pix_direct = '0;
        do_reset();
        @(posedge hclk);
        #1;
        chk({30'h0000_0000, hreadyout, hresp}, 32'h0000_0002);
        chk(hrdata, 32'h0000_0000);
        chk({29'h0000_0000, out_valid}, 32'h0000_0000);
        // Unwritten entries: colours unknown, unused bits zero
        for (i = 0; i < 3; i++) begin
            bus_read(base[i] + 32'h0000_0014, rd);
            chk(rd & 32'h7F03_0303, 32'h0000_0000);
        end
        // First and last entry of each table, read back at once
        for (i = 0; i < 3; i++) begin
            for (j = 0; j < 2; j++) begin
                bus_write(base[i] + (j * 32'h0000_03FC), pat[i][j]);
                bus_read(base[i] + (j * 32'h0000_03FC), rd);
                chk(rd, pat[i][j] & 32'h80FC_FCFC);
            end
        end
        // Write then read with no gap, layer one entry 16
        bus_wr_rd(32'h0000_0840, 32'hA5A5_5A5A, rd);
        chk(rd, 32'h80A4_5858);
        // No table aliasing over another: recheck after all writes
        for (i = 0; i < 3; i++) begin
            bus_read(base[i], rd);
            chk(rd, pat[i][0] & 32'h80FC_FCFC);
        end
        // Gaps around the tables hold nothing
        bus_write(32'h0000_0C00, 32'hFFFF_FFFF);
        bus_read(32'h0000_0C00, rd);
        chk(rd, 32'h0000_0000);
        bus_read(32'h0000_07FC, rd);
        chk(rd, 32'h0000_0000);
        bus_read(32'h0000_1800, rd);
        chk(rd, 32'h0000_0000);
        // Seven table writes so far; the gap write is not counted
        bus_read(32'h0000_1C04, rd);
        chk(rd, 32'h0007_0000);
        // Indirect on all layers, blending mode on then off
        bus_write(32'h0000_1C00, 32'h0000_000F);
        bus_read(32'h0000_1C00, rd);
        chk(rd, 32'h0000_000F);
        pix_all(0, 1'b1);
        pix_all(1, 1'b1);
        bus_write(32'h0000_1C00, 32'h0000_0007);
        pix_all(0, 1'b0);
        // Direct mode bypasses the tables
        bus_write(32'h0000_1C00, 32'h0000_0008);
        @(posedge hclk);
        pix_valid <= 3'h7;
        pix_direct[0] <= 18'h2_A5C3;
        pix_direct[1] <= 18'h1_5A3C;
        pix_direct[2] <= 18'h3_0F81;
        @(posedge hclk);
        pix_valid <= 3'h0;
        @(posedge hclk);
        #1;
        chk({14'h0000, out_red[0], out_green[0], out_blue[0]},
            32'h0002_A5C3);
        chk({14'h0000, out_red[1], out_green[1], out_blue[1]},
            32'h0001_5A3C);
        chk({14'h0000, out_red[2], out_green[2], out_blue[2]},
            32'h0003_0F81);
        chk({29'h0000_0000, out_blend}, 32'h0000_0007);
        // Second reset: bus idle state back, table bits still masked
        @(posedge hclk);
        do_reset();
        @(posedge hclk);
        #1;
        chk({31'h0000_0000, hreadyout}, 32'h0000_0001);
        bus_read(32'h0000_1C00, rd);
        chk(rd, 32'h0000_0000);
        bus_read(32'h0000_1C04, rd);
        chk(rd, 32'h0000_0000);
        bus_read(32'h0000_17FC, rd);
        chk(rd & 32'h7F03_0303, 32'h0000_0000);
        end_of_test();
    end
endmodule

`default_nettype wire
